// File: hdl/ospt_timer.sv
// 16-bit timer channel with triggered one-shot and pwm output modes
//
// What this block does
// - in triggered pulse modes, counter equal to compare 1 raises cmp1_irq
// - mode field 011 selects one-shot pulse mode
// - one-shot: count_enable arms, trig_in edge starts count, one pulse on pulse_out1
// - one-shot with soft_trigger: pulse_out0 active while counting, inactive waiting
// - one-shot trigger moves counter FFFFH to 0000H, then one step per tick
// - after the pulse the counter sits at 0000H, halts and waits again
// - triggers arriving while a pulse is in progress are ignored
// - pulse starts after cmp_reg1 ticks, lasts cmp_reg0 minus cmp_reg1 plus one
// - one-shot: cmp0_irq on step after match with cmp_buf0; cmp1_irq on cmp_buf1
// - one-shot: cmp1_irq when counter equals compare 1 value
// - one-shot: compare 1 match raises cmp1_irq and drives pulse_out1 active
// - one-shot: compare 0 match raises cmp0_irq, drops pulse_out1, stops counting
// - one-shot with cmp_reg1 above cmp_reg0 gives no pulse at all
// - compare 0 lowered past the count: counter overflows, clears at new value
// - compare 1 lowered past the count: pulse_out1 not raised that pass
// - mode field 100 selects pwm output mode
// - pwm: count_enable takes counter FFFFH to 0000H, waveform on pulse_out1
// - pwm period is cmp_reg0 plus one ticks, active width cmp_reg1 ticks
// - pwm: pulse_out0 toggles every pwm period
// - pwm: compare writes take effect only when counter clears on cmp_buf0
// - pwm: cmp0_irq as counter clears after cmp_buf0 match; cmp1_irq on cmp_buf1
// - reading the counter register returns the live 16-bit count
// - io control 1 and option 0 registers do not affect these modes
// - pwm: compare 0 reaches cmp_buf0 only after a compare 1 write, at clear
`timescale 1ns/10ps
`default_nettype none

module ospt_timer
  import ospt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire ospt_bus_req_t bus_req,
  output var logic [DATA_W-1:0] rd_data,
  // count clock enable from the prescaler, same clock domain
  input wire logic count_tick,
  // external trigger pin, asynchronous
  input wire logic trig_in,
  // waveform pins and compare events
  output var ospt_wave_t wave
);

  // address hit for a write strobe
  function automatic logic wr_hit(input ospt_bus_req_t req, input logic [ADDR_W-1:0] off);
    wr_hit = req.wr_en && (req.addr == off);
  endfunction : wr_hit

  // software registers
  logic count_enable;
  logic [MODE_W-1:0] mode_field;
  logic [CFG_W-1:0] io_control_1;
  logic [CFG_W-1:0] io_control_2;
  logic [CFG_W-1:0] option_reg_0;
  logic [DATA_W-1:0] cmp_reg0;
  logic [DATA_W-1:0] cmp_reg1;
  logic soft_trigger;

  // compare buffers and counter state
  logic [DATA_W-1:0] cmp_buf0;
  logic [DATA_W-1:0] cmp_buf1;
  logic reload_pending;
  logic [DATA_W-1:0] cnt;
  ospt_state_t state;
  logic sw_run;

  // trigger synchroniser
  logic trig_s1;
  logic trig_s2;
  logic trig_s3;

  // combinational terms
  logic is_oneshot;
  logic is_pwm;
  logic wr_cmp1;
  logic trig_edge;
  logic any_trig;
  logic run_tick;
  logic match0;
  logic match1;
  logic transfer;
  logic [DATA_W-1:0] next_cnt;
  logic [DATA_W-1:0] eff_buf1;

  assign is_oneshot = (mode_field == MODE_ONESHOT);
  assign is_pwm = (mode_field == MODE_PWM);
  assign wr_cmp1 = wr_hit(bus_req, OFF_CMP_REG1);
  assign trig_edge = trig_s2 && !trig_s3;
  assign any_trig = trig_edge || soft_trigger;
  assign run_tick = (state == ST_RUN) && count_enable && count_tick;
  // equality only: a compare moved below the count is passed by, so the count wraps
  assign match0 = (cnt == cmp_buf0);
  assign next_cnt = match0 ? CNT_CLEAR : cnt + CNT_STEP;
  assign transfer = is_pwm && run_tick && match0 && reload_pending;
  // at a pwm reload the new width governs the period that just starts
  assign eff_buf1 = transfer ? cmp_reg1 : cmp_buf1;
  // one-shot clear is not a compare 1 hit even when cmp_buf1 is zero
  assign match1 = (next_cnt == eff_buf1) && !(is_oneshot && match0);

  // two flops before the edge detector; only trig_s2 reads trig_s1
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      trig_s1 <= trig_in;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  // software register writes; io control 1 and option 0 are storage only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_enable <= 1'b0;
      mode_field <= RST_MODE;
      io_control_1 <= RST_CFG;
      io_control_2 <= RST_CFG;
      option_reg_0 <= RST_CFG;
      cmp_reg0 <= RST_CMP;
      cmp_reg1 <= RST_CMP;
    end else begin
      if (wr_hit(bus_req, OFF_CONTROL0)) begin
        count_enable <= bus_req.wr_data[BIT_COUNT_ENABLE];
      end
      if (wr_hit(bus_req, OFF_CONTROL1)) begin
        mode_field <= bus_req.wr_data[MODE_LSB +: MODE_W];
      end
      if (wr_hit(bus_req, OFF_IO_CTRL1)) begin
        io_control_1 <= bus_req.wr_data[CFG_W-1:0];
      end
      if (wr_hit(bus_req, OFF_IO_CTRL2)) begin
        io_control_2 <= bus_req.wr_data[CFG_W-1:0];
      end
      if (wr_hit(bus_req, OFF_OPTION0)) begin
        option_reg_0 <= bus_req.wr_data[CFG_W-1:0];
      end
      if (wr_hit(bus_req, OFF_CMP_REG0)) begin
        cmp_reg0 <= bus_req.wr_data;
      end
      if (wr_cmp1) begin
        cmp_reg1 <= bus_req.wr_data;
      end
    end
  end

  // soft trigger is a self-clearing one-cycle strobe; it reads back as zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      soft_trigger <= 1'b0;
    end else begin
      soft_trigger <= wr_hit(bus_req, OFF_CONTROL1) && bus_req.wr_data[BIT_SOFT_TRIGGER];
    end
  end

  // counter and sequencing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= RST_COUNT;
      state <= ST_OFF;
      sw_run <= 1'b0;
    end else if (!count_enable) begin
      state <= ST_OFF; // count holds its value
      sw_run <= 1'b0;
    end else begin
      case (state)
        ST_OFF: begin
          if (is_pwm) begin
            cnt <= RST_COUNT; // first tick wraps to 0000H
            state <= ST_RUN;
          end else if (is_oneshot) begin
            state <= ST_WAIT; // armed
          end
        end
        ST_WAIT: begin
          if (!is_oneshot) begin
            state <= ST_OFF;
          end else if (any_trig) begin
            cnt <= RST_COUNT;
            state <= ST_RUN;
            sw_run <= soft_trigger && !trig_edge;
          end
        end
        ST_RUN: begin
          // triggers are not looked at here
          if (!is_oneshot && !is_pwm) begin
            state <= ST_OFF;
          end else if (count_tick) begin
            cnt <= next_cnt;
            if (is_oneshot && match0) begin
              state <= ST_WAIT; // parked at 0000H
              sw_run <= 1'b0;
            end
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // compare buffers: live copy in one-shot, reload at clear in pwm
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmp_buf0 <= RST_CMP;
      cmp_buf1 <= RST_CMP;
      reload_pending <= 1'b0;
    end else if (is_oneshot) begin
      cmp_buf0 <= cmp_reg0;
      cmp_buf1 <= cmp_reg1;
      reload_pending <= 1'b0;
    end else if (state == ST_OFF && count_enable && is_pwm) begin
      cmp_buf0 <= cmp_reg0;
      cmp_buf1 <= cmp_reg1;
      reload_pending <= wr_cmp1;
    end else if (transfer) begin
      cmp_buf0 <= cmp_reg0;
      cmp_buf1 <= cmp_reg1;
      reload_pending <= wr_cmp1; // a write in the same cycle stays pending
    end else if (wr_cmp1) begin
      reload_pending <= 1'b1;
    end
  end

  // compare events, one cycle each
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wave.cmp0_irq <= 1'b0;
      wave.cmp1_irq <= 1'b0;
    end else begin
      wave.cmp0_irq <= run_tick && match0;
      wave.cmp1_irq <= run_tick && match1;
    end
  end

  // pulse_out1: set/reset flop driven by the two matches
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wave.pulse_out1 <= 1'b0;
    end else if (state != ST_RUN || !count_enable) begin
      wave.pulse_out1 <= 1'b0;
    end else if (run_tick && is_oneshot) begin
      if (match0) begin
        wave.pulse_out1 <= 1'b0;
      end else if (match1) begin
        wave.pulse_out1 <= 1'b1; // cmp_reg1 above cmp_reg0 never gets here
      end
    end else if (run_tick && is_pwm) begin
      if (match1) begin
        wave.pulse_out1 <= 1'b0; // width cmp_buf1 ticks
      end else if (next_cnt == CNT_CLEAR) begin
        wave.pulse_out1 <= 1'b1; // period cmp_buf0 plus one
      end
    end
  end

  // pulse_out0: run flag for soft one-shot, divide-by-two of the pwm period
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wave.pulse_out0 <= 1'b0;
    end else if (!count_enable || state == ST_OFF) begin
      wave.pulse_out0 <= 1'b0;
    end else if (is_oneshot) begin
      wave.pulse_out0 <= sw_run && (state == ST_RUN);
    end else if (is_pwm && run_tick && match0) begin
      wave.pulse_out0 <= !wave.pulse_out0;
    end
  end

  // read data stands one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data <= '0;
    end else if (!bus_req.rd_en) begin
      rd_data <= '0;
    end else if (bus_req.addr == OFF_CONTROL0) begin
      rd_data <= {{(DATA_W-1){1'b0}}, count_enable};
    end else if (bus_req.addr == OFF_CONTROL1) begin
      rd_data <= {{(DATA_W-MODE_W){1'b0}}, mode_field};
    end else if (bus_req.addr == OFF_IO_CTRL1) begin
      rd_data <= {{(DATA_W-CFG_W){1'b0}}, io_control_1};
    end else if (bus_req.addr == OFF_IO_CTRL2) begin
      rd_data <= {{(DATA_W-CFG_W){1'b0}}, io_control_2};
    end else if (bus_req.addr == OFF_OPTION0) begin
      rd_data <= {{(DATA_W-CFG_W){1'b0}}, option_reg_0};
    end else if (bus_req.addr == OFF_CMP_REG0) begin
      rd_data <= cmp_reg0;
    end else if (bus_req.addr == OFF_CMP_REG1) begin
      rd_data <= cmp_reg1;
    end else if (bus_req.addr == OFF_COUNTER) begin
      rd_data <= cnt;
    end else if (bus_req.addr == OFF_STATUS) begin
      rd_data <= '0;
      rd_data[ST_BIT_RUNNING] <= (state == ST_RUN);
      rd_data[ST_BIT_WAITING] <= (state == ST_WAIT);
      rd_data[ST_BIT_RELOAD] <= reload_pending;
      rd_data[ST_BIT_OUT0] <= wave.pulse_out0;
      rd_data[ST_BIT_OUT1] <= wave.pulse_out1;
    end else begin
      rd_data <= '0;
    end
  end

  // checks on the channel behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_trig_start;
    (state == ST_WAIT) && count_enable && is_oneshot && any_trig
      |=> (state == ST_RUN) && (cnt == RST_COUNT);
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("one-shot trigger did not start the counter at FFFFH");

  property p_oneshot_end;
    run_tick && is_oneshot && match0 && $stable(count_enable)
      |=> (cnt == CNT_CLEAR) && (state == ST_WAIT) && wave.cmp0_irq && !wave.pulse_out1;
  endproperty
  a_oneshot_end: assert property (p_oneshot_end)
    else $error("compare 0 match did not end the one-shot pulse");

  property p_ignore_trig;
    (state == ST_RUN) && count_enable && is_oneshot && any_trig && !(count_tick && match0)
      |=> (state == ST_RUN) && (cnt == ($past(count_tick) ? $past(cnt) + CNT_STEP : $past(cnt)));
  endproperty
  a_ignore_trig: assert property (p_ignore_trig)
    else $error("trigger during a pulse disturbed the counter");

  property p_cmp1_set;
    run_tick && is_oneshot && !match0 && (cnt + CNT_STEP == cmp_buf1)
      |=> wave.cmp1_irq && wave.pulse_out1 && (cnt == $past(cmp_buf1));
  endproperty
  a_cmp1_set: assert property (p_cmp1_set)
    else $error("compare 1 match did not raise pulse_out1 and cmp1_irq");

  property p_step;
    run_tick && (is_oneshot || is_pwm) && !match0 |=> (cnt == $past(cnt) + CNT_STEP);
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not advance by one on a count tick");

  property p_hold;
    !count_enable ##1 !count_enable |-> $stable(cnt);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved while count_enable is low");

  property p_pwm_clear;
    run_tick && is_pwm && match0 |=> (cnt == CNT_CLEAR) && wave.cmp0_irq
      && (wave.pulse_out0 != $past(wave.pulse_out0));
  endproperty
  a_pwm_clear: assert property (p_pwm_clear)
    else $error("pwm clear missed cmp0_irq or pulse_out0 toggle");

  property p_reload;
    transfer && !wr_hit(bus_req, OFF_CMP_REG0) |=> (cmp_buf0 == $past(cmp_reg0));
  endproperty
  a_reload: assert property (p_reload)
    else $error("pwm clear with pending reload did not load cmp_buf0");

  property p_no_early_reload;
    is_pwm && (state == ST_RUN) && !reload_pending ##1 is_pwm && (state == ST_RUN)
      |-> $stable(cmp_buf0) && $stable(cmp_buf1);
  endproperty
  a_no_early_reload: assert property (p_no_early_reload)
    else $error("compare buffer changed without a compare 1 write");

  property p_read_count;
    bus_req.rd_en && (bus_req.addr == OFF_COUNTER) |=> (rd_data == $past(cnt));
  endproperty
  a_read_count: assert property (p_read_count)
    else $error("counter read returned a stale value");

  property p_pwm_start;
    (state == ST_OFF) && count_enable && is_pwm |=> (state == ST_RUN) && (cnt == RST_COUNT);
  endproperty
  a_pwm_start: assert property (p_pwm_start)
    else $error("pwm enable did not load FFFFH and start");

  // main scenarios
  c_oneshot_pulse: cover property (is_oneshot && wave.pulse_out1 ##[1:64] wave.cmp0_irq);
  c_soft_oneshot: cover property (is_oneshot && wave.pulse_out0);
  c_pwm_period: cover property (is_pwm && wave.cmp1_irq ##[1:64] wave.cmp0_irq);
  c_pwm_reload: cover property (transfer);

endmodule : ospt_timer

`default_nettype wire

// File: hdl/ospt_pkg.sv
// shared constants and carrier types for the one-shot / pwm timer channel
package ospt_pkg;

  // register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CFG_W = 8;

  // register offsets (word index on the plain register port)
  localparam logic [ADDR_W-1:0] OFF_CONTROL0 = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CONTROL1 = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_IO_CTRL1 = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_IO_CTRL2 = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_OPTION0 = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_CMP_REG0 = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_CMP_REG1 = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_COUNTER = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;

  // field positions
  localparam int BIT_COUNT_ENABLE = 0;
  localparam int BIT_SOFT_TRIGGER = 6;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int ST_BIT_RUNNING = 0;
  localparam int ST_BIT_WAITING = 1;
  localparam int ST_BIT_RELOAD = 2;
  localparam int ST_BIT_OUT0 = 3;
  localparam int ST_BIT_OUT1 = 4;

  // mode field encodings
  localparam logic [MODE_W-1:0] MODE_ONESHOT = 3'h3;
  localparam logic [MODE_W-1:0] MODE_PWM = 3'h4;

  // reset and load values
  localparam logic [DATA_W-1:0] RST_COUNT = 16'hFFFF;
  localparam logic [DATA_W-1:0] CNT_CLEAR = 16'h0000;
  localparam logic [DATA_W-1:0] CNT_STEP = 16'h0001;
  localparam logic [DATA_W-1:0] RST_CMP = 16'h0000;
  localparam logic [CFG_W-1:0] RST_CFG = 8'h00;
  localparam logic [MODE_W-1:0] RST_MODE = 3'h0;

  // channel sequencing
  typedef enum logic [1:0] {
    ST_OFF,
    ST_WAIT,
    ST_RUN
  } ospt_state_t;

  // one register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic wr_en;
    logic rd_en;
  } ospt_bus_req_t;

  // waveform pins and compare events
  typedef struct packed {
    logic pulse_out0;
    logic pulse_out1;
    logic cmp0_irq;
    logic cmp1_irq;
  } ospt_wave_t;

endpackage : ospt_pkg

// File: bench/ospt_partner.sv
// far-side model: trigger source on trig_in and monitor of the waveform pins
`timescale 1ns/10ps
`default_nettype none

module ospt_partner
  import ospt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // requests from the bench
  input wire logic fire,
  input wire logic clr,
  // pins
  input wire ospt_wave_t wave,
  output wire logic trig_in,
  // measurements, in clock cycles or event counts
  output var logic [15:0] n_out1,
  output var logic [15:0] width1,
  output var logic [15:0] period1,
  output var logic [15:0] period0,
  output var logic [15:0] gap01,
  output var logic [15:0] n_out0,
  output var logic [15:0] n_irq0,
  output var logic [15:0] n_irq1
);
  logic trig_q = 1'b0;
  logic last0;
  logic last1;
  logic [15:0] hold;
  logic [15:0] run1;
  logic [15:0] since0;
  logic [15:0] since1;

  assign trig_in = trig_q;

  // trigger held four clocks so the pin synchroniser cannot miss the edge
  always @(posedge clk) begin
    if (reset) begin
      hold <= 16'h0000;
      trig_q <= 1'b0;
    end else if (fire) begin
      hold <= 16'h0004;
      trig_q <= 1'b1;
    end else if (hold > 16'h0001) begin
      hold <= hold - 16'h0001;
    end else begin
      trig_q <= 1'b0;
    end
  end

  // edge, width and period bookkeeping; clr restarts it without false edges
  always @(posedge clk) begin
    last0 <= wave.pulse_out0;
    last1 <= wave.pulse_out1;
    run1 <= wave.pulse_out1 ? run1 + 16'h0001 : 16'h0000;
    since0 <= since0 + 16'h0001;
    since1 <= since1 + 16'h0001;
    if (reset || clr) begin
      {n_out1, width1, period1, period0, gap01} <= '0;
      {n_out0, n_irq0, n_irq1, since0, since1} <= '0;
    end else begin
      if (wave.pulse_out1 && !last1) begin
        n_out1 <= n_out1 + 16'h0001;
        period1 <= since1;
        gap01 <= since0;
        since1 <= 16'h0001;
      end
      if (!wave.pulse_out1 && last1) width1 <= run1;
      if (wave.pulse_out0 && !last0) begin
        n_out0 <= n_out0 + 16'h0001;
        period0 <= since0;
        since0 <= 16'h0001;
      end
      if (wave.cmp0_irq) n_irq0 <= n_irq0 + 16'h0001;
      if (wave.cmp1_irq) n_irq1 <= n_irq1 + 16'h0001;
    end
  end
endmodule : ospt_partner

`default_nettype wire

// File: bench/ospt_timer_test.sv
// self-checking bench for the one-shot / pwm timer channel
`timescale 1ns/10ps
`default_nettype none

module ospt_timer_test
  import ospt_pkg::*;
;
  logic clk;
  logic reset;
  ospt_bus_req_t bus_req;
  logic [DATA_W-1:0] rd_data;
  logic count_tick;
  logic trig_in;
  ospt_wave_t wave;
  logic fire;
  logic clr;
  logic [15:0] n_out1, width1, period1, period0, gap01, n_out0, n_irq0, n_irq1;
  logic [15:0] v;
  logic [15:0] w;
  int errors;
  int n_checks;
  int cycles;

  ospt_timer ospt_timer_inst (.clk(clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
    .count_tick(count_tick), .trig_in(trig_in), .wave(wave));

  ospt_partner ospt_partner_inst (.clk(clk), .reset(reset), .fire(fire), .clr(clr),
    .wave(wave), .trig_in(trig_in), .n_out1(n_out1), .width1(width1), .period1(period1),
    .period0(period0), .gap01(gap01), .n_out0(n_out0), .n_irq0(n_irq0), .n_irq1(n_irq1));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // bus write: strobe stands one cycle beside address and data
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wr_data: d, wr_en: 1'b1, rd_en: 1'b0};
    @(posedge clk);
    bus_req.wr_en <= 1'b0;
  endtask : wr

  // bus read: data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wr_data: 16'h0000, wr_en: 1'b0, rd_en: 1'b1};
    @(posedge clk);
    bus_req.rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  // selectors for strobe; a ref argument would need a nonblocking write to a task formal
  localparam int S_CLR = 0;
  localparam int S_FIRE = 1;
  localparam int S_TICK = 2;

  // one-cycle high pulse on clr, fire or count_tick
  task automatic strobe(input int which);
    @(posedge clk);
    if (which == S_CLR) clr <= 1'b1;
    else if (which == S_FIRE) fire <= 1'b1;
    else count_tick <= 1'b1;
    @(posedge clk);
    if (which == S_CLR) clr <= 1'b0;
    else if (which == S_FIRE) fire <= 1'b0;
    else count_tick <= 1'b0;
  endtask : strobe

  task automatic test_reset;
    rd(OFF_COUNTER, v);
    check("counter after reset", 16'hFFFF, v);
    rd(4'h9, v);
    check("unmapped read", 16'h0000, v);
    check("pins after reset", 16'h0000, {12'h000, wave});
    $display("test_reset done");
  endtask : test_reset

  task automatic test_oneshot_soft;
    wr(OFF_CMP_REG0, 16'h0005);
    wr(OFF_CMP_REG1, 16'h0002);
    wr(OFF_CONTROL1, 16'h0003);
    wr(OFF_CONTROL0, 16'h0001);
    strobe(S_CLR);
    wr(OFF_CONTROL1, 16'h0043);
    repeat (4) @(posedge clk);
    wr(OFF_CONTROL1, 16'h0043);
    repeat (20) @(posedge clk);
    check("one-shot pulses", 16'h0001, n_out1);
    check("one-shot width", 16'h0004, width1);
    check("one-shot delay", 16'h0002, gap01);
    check("out0 runs", 16'h0001, n_out0);
    check("out0 idle", 16'h0000, {15'h0000, wave.pulse_out0});
    check("cmp1 events", 16'h0001, n_irq1);
    check("cmp0 events", 16'h0001, n_irq0);
    rd(OFF_COUNTER, v);
    check("counter parked", 16'h0000, v);
    $display("test_oneshot_soft done");
  endtask : test_oneshot_soft

  task automatic test_oneshot_pin;
    wr(OFF_CONTROL0, 16'h0000);
    wr(OFF_CMP_REG0, 16'h0003);
    wr(OFF_CMP_REG1, 16'h0003);
    wr(OFF_CONTROL0, 16'h0001);
    strobe(S_CLR);
    strobe(S_FIRE);
    repeat (20) @(posedge clk);
    check("pin pulses", 16'h0001, n_out1);
    check("pin width", 16'h0001, width1);
    check("pin out0", 16'h0000, n_out0);
    check("pin cmp1", 16'h0001, n_irq1);
    wr(OFF_CONTROL0, 16'h0000);
    wr(OFF_CMP_REG1, 16'h0005);
    wr(OFF_CONTROL0, 16'h0001);
    strobe(S_CLR);
    strobe(S_FIRE);
    repeat (20) @(posedge clk);
    check("late cmp1 pulses", 16'h0000, n_out1);
    check("late cmp1 cmp0", 16'h0001, n_irq0);
    $display("test_oneshot_pin done");
  endtask : test_oneshot_pin

  task automatic test_pwm;
    wr(OFF_CONTROL0, 16'h0000);
    wr(OFF_CONTROL1, 16'h0004);
    wr(OFF_CMP_REG0, 16'h0004);
    wr(OFF_CMP_REG1, 16'h0002);
    wr(OFF_CONTROL0, 16'h0001);
    strobe(S_CLR);
    repeat (30) @(posedge clk);
    check("pwm period", 16'h0005, period1);
    check("pwm width", 16'h0002, width1);
    check("out0 period", 16'h000A, period0);
    // window holds six width matches and five clears of a five-tick period
    check("pwm cmp0 events", 16'h0005, n_irq0);
    check("pwm cmp1 events", 16'h0006, n_irq1);
    wr(OFF_CMP_REG0, 16'h0006);
    repeat (20) @(posedge clk);
    check("held period", 16'h0005, period1);
    wr(OFF_CMP_REG1, 16'h0003);
    repeat (40) @(posedge clk);
    check("new period", 16'h0007, period1);
    check("new width", 16'h0003, width1);
    check("new out0 period", 16'h000E, period0);
    $display("test_pwm done");
  endtask : test_pwm

  task automatic test_hold;
    wr(OFF_IO_CTRL1, 16'h00FF);
    wr(OFF_OPTION0, 16'h00FF);
    strobe(S_CLR);
    repeat (30) @(posedge clk);
    check("period after unused regs", 16'h0007, period1);
    @(posedge clk);
    count_tick <= 1'b0;
    rd(OFF_COUNTER, v);
    repeat (5) @(posedge clk);
    rd(OFF_COUNTER, w);
    check("held count", v, w);
    strobe(S_TICK);
    rd(OFF_COUNTER, w);
    check("one step", (v == 16'h0006) ? 16'h0000 : v + 16'h0001, w);
    @(posedge clk);
    count_tick <= 1'b1;
    // an undecoded mode value parks the channel with all pins low
    wr(OFF_CONTROL1, 16'h0000);
    repeat (3) @(posedge clk);
    check("pins in idle mode", 16'h0000, {12'h000, wave});
    $display("test_hold done");
  endtask : test_hold

  // hang guard, far beyond the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      $display("CHECK FAILED run time expected under 5000 cycles seen %0d", cycles);
      close_out();
    end
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    bus_req = '0;
    count_tick = 1'b1;
    fire = 1'b0;
    clr = 1'b0;
    errors = 0;
    n_checks = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    test_reset();
    test_oneshot_soft();
    test_oneshot_pin();
    test_pwm();
    test_hold();
    close_out();
  end
endmodule : ospt_timer_test

`default_nettype wire
